/* logic/adc_port_pkg.sv */
// shared constants and types for the sample output port
package adc_port_pkg;

	// word widths and pipeline figures
	localparam int CODE_W = 12;
	localparam int ANALOG_W = 14;
	localparam int LATENCY = 5;
	localparam int PIPE_DEPTH = LATENCY;
	localparam int SYNC_CTL_W = 6;
	localparam int PERIOD_W = 8;
	localparam int COUNT_W = 16;

	// conversion range in lsb units around midscale
	localparam logic signed [ANALOG_W-1:0] CODE_MAX = 14'sh07FF;
	localparam logic signed [ANALOG_W-1:0] CODE_MIN = -14'sh0800;
	localparam logic [CODE_W-1:0] CLAMP_HI = 12'h7FF;
	localparam logic [CODE_W-1:0] CLAMP_LO = 12'h800;

	// positions inside the synchronised control word
	localparam int CTL_ENC_T = 0;
	localparam int CTL_ENC_C = 1;
	localparam int CTL_PWRDN = 2;
	localparam int CTL_OEN = 3;
	localparam int CTL_FMT_LO = 4;
	localparam int CTL_FMT_HI = 5;

	// register byte offsets
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
	localparam logic [7:0] COUNT_OFS = 8'h10;

	// field positions and reset values
	localparam int CTRL_CONV_BIT = 0;
	localparam logic CTRL_CONV_RST = 1'b1;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_TWOS_BIT = 4;
	localparam int ST_STAB_BIT = 5;
	localparam int ST_CODE_LSB = 16;
	localparam int ST_FLAG_BIT = 28;
	localparam int EV_RESULT = 0;
	localparam int EV_RANGE = 1;
	localparam int EV_MODE = 2;
	localparam int EV_W = 3;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;

	// operating modes selected by the two static pins
	typedef enum logic [3:0] {
		MODE_NORMAL = 4'b0001,
		MODE_HIZ = 4'b0010,
		MODE_NAP = 4'b0100,
		MODE_SLEEP = 4'b1000
	} op_mode_t;

endpackage : adc_port_pkg

/* logic/adc_sample_output_port.sv */
// digital side of the 12-bit sampling converter with its output port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - a new sample is taken on each rising edge of the sample clock
// - power-down low, enable low: convert and drive all outputs
// - power-down low, enable high: keep converting, outputs released
// - power-down high, enable low: nap, no conversion, outputs released
// - power-down high, enable high: sleep, no conversion, outputs released
// - result is a 12-bit word, bit 11 the most significant
// - range flag goes high with a word whose input left the range
// - format level 0 and 1/3: offset binary, stabilizer off then on
// - format level 2/3 and full: two's complement, stabilizer on then off
// - in two's complement all-ones and all-zeros meet at midscale
// - result appears five sample clocks after its sample, one per clock
// - input tracked while sample clock low, held at its rising edge
module adc_sample_output_port
	import adc_port_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic sample_clock_true_i,
	input wire logic sample_clock_comp_i,
	input wire logic power_down_select_i,
	input wire logic output_enable_n_i,
	input wire logic [1:0] format_level_i,
	input wire logic [ANALOG_W-1:0] analog_level_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	output logic [CODE_W-1:0] sample_code_o,
	output logic range_exceeded_flag_o,
	output logic data_valid_strobe_o,
	output logic digital_oe_o
);
	logic [SYNC_CTL_W-1:0] ctl_s;
	logic signed [ANALOG_W-1:0] analog_s;
	logic enc_ff;
	logic enc_level;
	logic enc_rise;
	op_mode_t mode_ff;
	op_mode_t nxt_mode;
	logic twos_fmt;
	logic stab_on;
	logic converting;
	logic pipe_adv;
	logic signed [ANALOG_W-1:0] held_ff;
	logic conv_over;
	logic conv_under;
	logic [CODE_W-1:0] conv_code;
	logic [CODE_W:0] pipe_dout;
	logic pipe_vld;
	logic [CODE_W-1:0] code_ff;
	logic flag_ff;
	logic res_ev;
	logic [PERIOD_W-1:0] period_ff;
	logic [PERIOD_W-1:0] half_ff;
	logic [PERIOD_W-1:0] hi_cnt_ff;
	logic strobe_ff;
	logic wb_hit;
	logic wb_wr;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [31:0] rd_mux;
	logic ctrl_conv_ff;
	logic [EV_W-1:0] irq_stat_ff;
	logic [EV_W-1:0] irq_mask_ff;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_clr;
	logic irq_ff;
	logic [COUNT_W-1:0] count_ff;

	// pins from outside the clock domain
	pin_sync #(.W(SYNC_CTL_W)) u_ctl_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i({format_level_i, output_enable_n_i, power_down_select_i,
			sample_clock_comp_i, sample_clock_true_i}),
		.sync_o(ctl_s)
	);

	pin_sync #(.W(ANALOG_W)) u_analog_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i(analog_level_i),
		.sync_o(analog_s)
	);

	// differential clock level; equal legs keep the last level
	always_comb begin
		enc_level = enc_ff;
		if (ctl_s[CTL_ENC_T] && !ctl_s[CTL_ENC_C]) begin
			enc_level = 1'b1;
		end else if (!ctl_s[CTL_ENC_T] && ctl_s[CTL_ENC_C]) begin
			enc_level = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enc_ff <= 1'b0;
		end else if (ce_i) begin
			enc_ff <= enc_level;
		end
	end

	assign enc_rise = enc_level && !enc_ff;

	// operating mode from the two static pins
	always_comb begin
		case ({ctl_s[CTL_PWRDN], ctl_s[CTL_OEN]})
			2'b00: nxt_mode = MODE_NORMAL;
			2'b01: nxt_mode = MODE_HIZ;
			2'b10: nxt_mode = MODE_NAP;
			2'b11: nxt_mode = MODE_SLEEP;
			default: nxt_mode = MODE_SLEEP;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_ff <= MODE_SLEEP;
		end else if (ce_i) begin
			mode_ff <= nxt_mode;
		end
	end

	// format pin: top bit picks code, xor picks stabilizer
	assign twos_fmt = ctl_s[CTL_FMT_HI];
	assign stab_on = ctl_s[CTL_FMT_HI] ^ ctl_s[CTL_FMT_LO];

	assign converting = ctrl_conv_ff &&
		(mode_ff == MODE_NORMAL || mode_ff == MODE_HIZ);
	assign pipe_adv = enc_rise && converting;

	// track while low, freeze once the clock goes high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			held_ff <= '0;
		end else if (ce_i && !enc_level) begin
			held_ff <= analog_s;
		end
	end

	// clamp to range; two's complement kept internally
	assign conv_over = held_ff > CODE_MAX;
	assign conv_under = held_ff < CODE_MIN;
	always_comb begin
		conv_code = held_ff[CODE_W-1:0];
		if (conv_over) begin
			conv_code = CLAMP_HI;
		end else if (conv_under) begin
			conv_code = CLAMP_LO;
		end
	end

	result_pipeline u_pipe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.advance_i(pipe_adv),
		.flush_i(mode_ff == MODE_SLEEP),
		.din_i({conv_over || conv_under, conv_code}),
		.dout_o(pipe_dout),
		.valid_o(pipe_vld)
	);

	assign res_ev = pipe_adv && pipe_vld;

	// output word, formatted on the way out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_ff <= '0;
			flag_ff <= 1'b0;
		end else if (ce_i && res_ev) begin
			if (twos_fmt) begin
				code_ff <= pipe_dout[CODE_W-1:0];
			end else begin
				code_ff <= {~pipe_dout[CODE_W-1],
					pipe_dout[CODE_W-2:0]};
			end
			flag_ff <= pipe_dout[CODE_W];
		end
	end

	// period measure for the stabilized strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			period_ff <= '0;
			half_ff <= '0;
		end else if (ce_i) begin
			if (enc_rise) begin
				half_ff <= period_ff >> 1;
				period_ff <= PERIOD_W'(1);
			end else if (period_ff != '1) begin
				period_ff <= period_ff + PERIOD_W'(1);
			end
		end
	end

	// strobe rises with new data, falls mid-period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_ff <= 1'b0;
			hi_cnt_ff <= '0;
		end else if (ce_i) begin
			if (!stab_on) begin
				strobe_ff <= enc_level;
			end else if (enc_rise) begin
				strobe_ff <= 1'b1;
				hi_cnt_ff <= PERIOD_W'(1);
			end else if (hi_cnt_ff >= half_ff) begin
				strobe_ff <= 1'b0;
			end else begin
				hi_cnt_ff <= hi_cnt_ff + PERIOD_W'(1);
			end
		end
	end

	assign sample_code_o = code_ff;
	assign range_exceeded_flag_o = flag_ff;
	assign data_valid_strobe_o = strobe_ff;
	assign digital_oe_o = mode_ff == MODE_NORMAL;

	// bus decode; ack a cycle after the request, writes land with ack
	assign wb_hit = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;

	always_comb begin
		rd_mux = '0;
		case (wb_adr_i)
			STATUS_OFS: begin
				rd_mux[ST_MODE_LSB +: 4] = mode_ff;
				rd_mux[ST_TWOS_BIT] = twos_fmt;
				rd_mux[ST_STAB_BIT] = stab_on;
				rd_mux[ST_CODE_LSB +: CODE_W] = code_ff;
				rd_mux[ST_FLAG_BIT] = flag_ff;
			end
			CTRL_OFS: rd_mux[CTRL_CONV_BIT] = ctrl_conv_ff;
			IRQ_STAT_OFS: rd_mux[EV_W-1:0] = irq_stat_ff;
			IRQ_MASK_OFS: rd_mux[EV_W-1:0] = irq_mask_ff;
			COUNT_OFS: rd_mux[COUNT_W-1:0] = count_ff;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdata_ff <= '0;
		end else if (ce_i) begin
			ack_ff <= wb_hit;
			if (wb_hit) begin
				rdata_ff <= wb_we_i ? 32'h0 : rd_mux;
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;

	// control and mask registers, low byte lane
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_conv_ff <= CTRL_CONV_RST;
			irq_mask_ff <= IRQ_MASK_RST;
		end else if (ce_i && wb_wr && wb_sel_i[0]) begin
			if (wb_adr_i == CTRL_OFS) begin
				ctrl_conv_ff <= wb_dat_i[CTRL_CONV_BIT];
			end
			if (wb_adr_i == IRQ_MASK_OFS) begin
				irq_mask_ff <= wb_dat_i[EV_W-1:0];
			end
		end
	end

	// sticky events; a new event beats a same-cycle clear
	always_comb begin
		ev_set = '0;
		ev_set[EV_RESULT] = res_ev;
		ev_set[EV_RANGE] = res_ev && pipe_dout[CODE_W];
		ev_set[EV_MODE] = nxt_mode != mode_ff;
		ev_clr = '0;
		if (wb_wr && wb_sel_i[0] && wb_adr_i == IRQ_STAT_OFS) begin
			ev_clr = wb_dat_i[EV_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_ff <= '0;
			irq_ff <= 1'b0;
			count_ff <= '0;
		end else if (ce_i) begin
			irq_stat_ff <= (irq_stat_ff & ~ev_clr) | ev_set;
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
			if (res_ev) begin
				count_ff <= count_ff + COUNT_W'(1);
			end
		end
	end

	assign irq_o = irq_ff;

	// checks on the guarded behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	drive_normal_a: assert property (
		ctl_s[CTL_PWRDN +: 2] == 2'b00 |=> digital_oe_o)
		else $error("outputs not driven in normal mode");
	hiz_converts_a: assert property (
		mode_ff == MODE_HIZ && ctrl_conv_ff && enc_rise && pipe_vld
		|=> !digital_oe_o && count_ff == $past(count_ff) + COUNT_W'(1))
		else $error("released outputs stopped conversion");
	nap_stops_a: assert property (
		mode_ff == MODE_NAP |-> !digital_oe_o ##1 $stable(sample_code_o))
		else $error("nap mode still converting");
	sleep_flush_a: assert property (
		mode_ff == MODE_SLEEP ##1 mode_ff == MODE_SLEEP |-> !pipe_vld
		&& !digital_oe_o)
		else $error("sleep mode kept results");
	track_hold_a: assert property (
		enc_ff && enc_level ##1 enc_level |-> $stable(held_ff))
		else $error("held sample moved while clock high");
	range_flag_a: assert property (
		res_ev |=> range_exceeded_flag_o == $past(pipe_dout[CODE_W]))
		else $error("range flag lost");
	format_msb_a: assert property (
		res_ev |=> sample_code_o[CODE_W-1] ==
		($past(pipe_dout[CODE_W-1]) ^ !$past(twos_fmt)))
		else $error("wrong output format");
	midscale_a: assert property (
		held_ff == -14'sh0001 |-> conv_code == 12'hFFF && !conv_over)
		else $error("minus one not all ones");
	word_change_a: assert property (
		$changed(sample_code_o) |-> $past(res_ev))
		else $error("word changed off a clock rise");
	strobe_rise_a: assert property (
		res_ev |=> data_valid_strobe_o)
		else $error("strobe low with new data");
	event_sticky_a: assert property (
		res_ev |=> irq_stat_ff[EV_RESULT])
		else $error("result event lost");

	cover_nap_c: cover property (mode_ff == MODE_NAP);
	cover_range_c: cover property (res_ev && pipe_dout[CODE_W]);
	cover_irq_c: cover property ($rose(irq_o));
	cover_hiz_c: cover property (mode_ff == MODE_HIZ && res_ev);
endmodule : adc_sample_output_port
`default_nettype wire

/* logic/pin_sync.sv */
// three-stage synchroniser that accepts a word once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;

	// chain; first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else if (ce_i) begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// accept only a settled value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff <= '0;
		end else if (ce_i && s2_ff == s3_ff) begin
			q_ff <= s3_ff;
		end
	end

	assign sync_o = q_ff;
endmodule : pin_sync
`default_nettype wire

/* logic/result_pipeline.sv */
// result pipeline that advances one stage per sample-clock rise
`timescale 1ns/1ps
`default_nettype none
module result_pipeline
	import adc_port_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic advance_i,
	input wire logic flush_i,
	input wire logic [CODE_W:0] din_i,
	output logic [CODE_W:0] dout_o,
	output logic valid_o
);
	logic [CODE_W:0] stage_ff [PIPE_DEPTH];
	logic vld_ff [PIPE_DEPTH];

	// one stage per entry; entry zero takes the new sample
	for (genvar i = 0; i < PIPE_DEPTH; i++) begin : g_stage
		logic [CODE_W:0] src;
		logic src_vld;
		// source picked at elaboration, so no stage indexes below zero
		if (i == 0) begin : g_head
			assign src = din_i;
			assign src_vld = 1'b1;
		end else begin : g_body
			assign src = stage_ff[i-1];
			assign src_vld = vld_ff[i-1];
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				stage_ff[i] <= '0;
				vld_ff[i] <= 1'b0;
			end else if (ce_i) begin
				if (flush_i) begin
					vld_ff[i] <= 1'b0;
				end else if (advance_i) begin
					stage_ff[i] <= src;
					vld_ff[i] <= src_vld;
				end
			end
		end
	end

	assign dout_o = stage_ff[PIPE_DEPTH-1];
	assign valid_o = vld_ff[PIPE_DEPTH-1];
endmodule : result_pipeline
`default_nettype wire

/* testbench/adc_sample_output_port_tb.sv */
// self-checking bench for the sample output port
`timescale 1ns/1ps
`default_nettype none
module adc_sample_output_port_tb;
	import adc_port_pkg::*;
	localparam logic [ANALOG_W-1:0] CORN [8] = '{14'h07FF, 14'h0800,
		14'h3800, 14'h37FF, 14'h0000, 14'h3FFF, 14'h0001, 14'h3FFE};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic run = 1'b0;
	logic track = 1'b0;
	logic pd = 1'b0;
	logic oe_n = 1'b0;
	logic [1:0] fmt = 2'h0;
	logic signed [ANALOG_W-1:0] ana = 14'h0000;
	logic signed [ANALOG_W-1:0] nxt;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, dat_o, c0;
	logic ack, irq, strobe, oe, flag, sample_clock, got;
	logic enc_ff = 1'b0;
	logic [CODE_W-1:0] code;
	logic [CODE_W:0] word;
	logic [31:0] seed = 32'hD87B;
	logic signed [ANALOG_W-1:0] q[$];
	int n_mismatch = 0;
	int num_checks = 0;
	int n_rise = 0;
	int n_got = 0;
	int n_cap = 0;

	// system clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	adc_sample_output_port dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.sample_clock_true_i(sample_clock), .sample_clock_comp_i(~sample_clock),
		.power_down_select_i(pd), .output_enable_n_i(oe_n),
		.format_level_i(fmt), .analog_level_i(ana), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
		.sample_code_o(code), .range_exceeded_flag_o(flag),
		.data_valid_strobe_o(strobe), .digital_oe_o(oe));

	sample_receiver rx (.clk_i(clk_i), .run_i(run), .strobe_i(strobe),
		.oe_i(oe), .code_i(code), .flag_i(flag),
		.sample_clock_true_o(sample_clock), .got_o(got), .word_o(word));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	// expected word and flag for one analog level and format pin
	function automatic logic [CODE_W:0] exp_word(
		input logic signed [ANALOG_W-1:0] a, input logic [1:0] f);
		logic [CODE_W:0] w;
		if (a > CODE_MAX) w = {1'b1, CLAMP_HI};
		else if (a < CODE_MIN) w = {1'b1, CLAMP_LO};
		else w = {1'b0, a[CODE_W-1:0]};
		if (!f[1]) w[CODE_W-1] = ~w[CODE_W-1];
		return w;
	endfunction : exp_word

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e,
		input string m);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk_val

	task automatic chk_word(input logic [CODE_W:0] g,
		input logic [CODE_W:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t word got %h exp %h", $time, g, e);
		end
	endtask : chk_word

	// one classic bus cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// only the watchdog ends a wait that never sees ack
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string s);
		wb(1'b0, a, 32'h0);
		chk_val(rdat & m, e, s);
	endtask : rd_chk

	task automatic run_periods(input int n);
		int t;
		t = n_rise + n;
		run <= 1'b1;
		while (n_rise < t) @(posedge clk_i);
		run <= 1'b0;
		repeat (80) @(posedge clk_i);
	endtask : run_periods

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run

	// new analog level each sample clock fall, held over the rise
	always @(posedge clk_i) begin
		enc_ff <= sample_clock;
		if (!enc_ff && sample_clock) n_rise++;
		if (enc_ff && !sample_clock) begin
			seed = xs(seed);
			nxt = (seed[31:29] == 3'h0) ? CORN[seed[2:0]] :
				{seed[12], seed[12:0]};
			ana <= nxt;
			if (track) q.push_back(nxt);
		end
	end

	// compare captured words in order, stepping the format pin
	always @(posedge clk_i) begin
		if (track && got === 1'b1) begin
			n_cap++;
			// captures before the pipeline fills still show the reset word
			if (n_cap > LATENCY) begin
				n_got++;
				chk_word(word, exp_word(q.pop_front(), fmt));
				if (n_got % 15 == 0) fmt <= fmt + 2'h1;
			end else begin
				chk_word(word, '0);
			end
		end
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		complete_run();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		rd_chk(CTRL_OFS, 32'h1, 32'h1, "ctrl");
		rd_chk(IRQ_MASK_OFS, 32'h7, 32'h0, "mask");
		rd_chk(8'h14, 32'hFFFFFFFF, 32'h0, "unmapped");
		rd_chk(STATUS_OFS, 32'hF, 32'h1, "mode");
		chk_val({31'h0, oe}, 32'h1, "oe");
		q.push_back(ana);
		track <= 1'b1;
		run_periods(60);
		chk_val(q.size(), 32'h6, "in flight");
		chk_val(n_got, 32'h37, "captures");
		rd_chk(STATUS_OFS, 32'h30, 32'h10, "format");
		track <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			pd <= (i == 1 || i == 2);
			oe_n <= (i == 0 || i == 2);
			repeat (12) @(posedge clk_i);
			rd_chk(STATUS_OFS, 32'hF, (32'h1842 >> (i * 4)) & 32'hF,
				"mode");
			chk_val({31'h0, oe}, {31'h0, i == 3}, "oe");
			wb(1'b0, COUNT_OFS, 32'h0);
			c0 = rdat;
			run_periods(8);
			wb(1'b0, COUNT_OFS, 32'h0);
			chk_val((rdat - c0) & 32'hFFFF, (32'h3008 >> (i * 4)) &
				32'hF, "count");
		end
		rd_chk(IRQ_STAT_OFS, 32'h7, 32'h7, "events");
		chk_val({31'h0, irq}, 32'h0, "irq masked");
		wb(1'b1, IRQ_MASK_OFS, 32'h4);
		repeat (3) @(posedge clk_i);
		chk_val({31'h0, irq}, 32'h1, "irq raised");
		wb(1'b1, IRQ_STAT_OFS, 32'h7);
		repeat (3) @(posedge clk_i);
		chk_val({31'h0, irq}, 32'h0, "irq cleared");
		rd_chk(IRQ_STAT_OFS, 32'h7, 32'h0, "events cleared");
		rd_chk(IRQ_MASK_OFS, 32'h7, 32'h4, "mask kept");
		complete_run();
	end
endmodule : adc_sample_output_port_tb
`default_nettype wire

/* testbench/sample_receiver.sv */
// receiving side: sample clock source and word capture
`timescale 1ns/1ps
`default_nettype none
module sample_receiver
	import adc_port_pkg::*;
(
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic strobe_i,
	input wire logic oe_i,
	input wire logic [CODE_W-1:0] code_i,
	input wire logic flag_i,
	output logic sample_clock_true_o,
	output logic got_o,
	output logic [CODE_W:0] word_o
);
	logic strobe_ff;
	// sample clock runs while asked, parked low between bursts
	initial begin
		sample_clock_true_o = 1'b0;
		forever begin
			wait (run_i === 1'b1);
			#62.5 sample_clock_true_o = 1'b1;
			#62.5 sample_clock_true_o = 1'b0;
		end
	end
	// latch word and flag on a falling strobe while driven
	always @(posedge clk_i) begin
		strobe_ff <= strobe_i;
		got_o <= oe_i & strobe_ff & ~strobe_i;
		if (oe_i & strobe_ff & ~strobe_i) begin
			word_o <= {flag_i, code_i};
		end
	end
endmodule : sample_receiver
`default_nettype wire
